// *** rtl/fls_pkg.sv ***
// Constants and types shared by the flash lock/blank/status sequencer
// How it works
// - Lock-program code then confirm at block top address clears block lock bit.
// - Lock-status code then confirm loads block lock state into lock state flag.
// - Blank-check code then confirm checks erasure; erase error one means not blank.
// - Blank check of a locked block sets erase error regardless of lock-disable.
// - Status byte: program error D4, erase error D5, ready D7; reset 0,0,1.
// - Ready reads zero while any array operation executes, one otherwise.
// - Error flags are cleared only by the clear-status command.
// - While either error flag is set, array operations are refused.
// - Bad command or bad second-cycle data sets both flags as sequence error.
// - Erase error on locked erase, failed erase, or not-blank check.
// - Program error on locked program, failed program, or failed lock write.
// - In status mode with erase-write mode zero, even-address reads return status until read-array or a lock-status read.
// - Read-array code in second cycle of a non-program command discards it, back to array.
// - Lock-disable set suppresses lock-related error conditions except in blank check.
// - Clear-status code resets both error flags to zero.
// - Read-status code makes even-address reads return the status byte in erase-write mode zero.
`default_nettype none
package fls_pkg;
  // ----------------------------------------
  // Command codes (low byte of bus data)
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h41;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_LOCK_PGM    = 8'h77;
  localparam logic [7:0] CMD_LOCK_RD     = 8'h71;
  localparam logic [7:0] CMD_BLANK       = 8'h25;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  // ----------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------
  localparam int         STAT_PGM_POS    = 4;
  localparam int         STAT_ERS_POS    = 5;
  localparam int         STAT_RDY_POS    = 7;
  localparam logic       PERR_RST        = 1'b0;
  localparam logic       EERR_RST        = 1'b0;
  localparam logic       LOCK_FLAG_RST   = 1'b0;
  localparam logic       SMODE_RST       = 1'b0;
  // ----------------------------------------
  // Array operations and sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_PROGRAM  = 3'b001,
    OP_ERASE    = 3'b010,
    OP_LOCK_PGM = 3'b011,
    OP_LOCK_RD  = 3'b100,
    OP_BLANK    = 3'b101
  } fls_op_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAIT2  = 3'b001,
    ST_PGM_W0 = 3'b010,
    ST_PGM_W1 = 3'b011,
    ST_BUSY   = 3'b100
  } fls_state_t;
endpackage
`default_nettype wire

// *** rtl/fls_err_class.sv ***
// Error classification of a finished array operation
`default_nettype none
module fls_err_class
  import fls_pkg::*;
(
  input  wire fls_op_t op,
  input  wire logic    lock_bit,
  input  wire logic    fail,
  input  wire logic    lock_disable_bit,
  output logic         set_perr,
  output logic         set_eerr
);
  // ----------------------------------------
  // Classification
  // ----------------------------------------
  // Lock bit zero means locked
  wire locked_err = ~lock_bit & ~lock_disable_bit;
  wire is_pgm     = (op == OP_PROGRAM);
  wire is_ers     = (op == OP_ERASE);
  wire is_lpgm    = (op == OP_LOCK_PGM);
  wire is_blank   = (op == OP_BLANK);
  // Failed lock write also falls under lock-disable suppression
  assign set_perr = (is_pgm & (locked_err | fail))
                  | (is_lpgm & fail & ~lock_disable_bit);
  // Blank check ignores lock-disable on purpose
  assign set_eerr = (is_ers & (locked_err | fail))
                  | (is_blank & (~lock_bit | fail));
endmodule
`default_nettype wire

// *** rtl/fls_sequencer.sv ***
// Flash command sequencer: lock bits, blank check and status flags
`default_nettype none
module fls_sequencer
  import fls_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [15:0]       bus_wdata,
  output logic      [15:0]       bus_rdata,
  output logic                   bus_rvalid,
  input  wire logic              erase_write_mode_zero,
  input  wire logic              lock_disable_bit,
  output logic                   sequencer_ready_flag,
  output logic                   program_error_flag,
  output logic                   erase_error_flag,
  output logic                   lock_state_flag,
  output logic      [7:0]        flash_status_byte,
  input  wire logic [15:0]       arr_rdata,
  output logic                   arr_start,
  output fls_op_t                arr_op,
  output logic      [ADDR_W-1:0] arr_addr,
  output logic      [31:0]       arr_wdata,
  output logic                   arr_lock_disable,
  input  wire logic              arr_done,
  input  wire logic              arr_fail,
  input  wire logic              arr_lock_bit
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  generate
    if (ADDR_W < 2) begin : g_bad_addr
      $error("fls_sequencer: ADDR_W must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic fls_op_t op_of(input logic [7:0] c);
    case (c)
      CMD_PROGRAM:  op_of = OP_PROGRAM;
      CMD_ERASE:    op_of = OP_ERASE;
      CMD_LOCK_PGM: op_of = OP_LOCK_PGM;
      CMD_LOCK_RD:  op_of = OP_LOCK_RD;
      CMD_BLANK:    op_of = OP_BLANK;
      default:      op_of = OP_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  fls_state_t        state_reg, state_next;
  logic [7:0]        cmd_reg, cmd_next;
  logic              perr_reg, perr_next;
  logic              eerr_reg, eerr_next;
  logic              lock_reg, lock_next;
  logic              smode_reg, smode_next;
  logic              start_reg, start_next;
  fls_op_t           op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [15:0]       rdata_reg, rdata_next;
  logic              rvalid_reg;
  logic              set_perr;
  logic              set_eerr;

  wire [7:0] code     = bus_wdata[7:0];
  wire       err_any  = perr_reg | eerr_reg;
  wire       ready    = (state_reg != ST_BUSY);
  wire       first_op = (op_of(code) != OP_NONE);
  wire       is_ra    = (code == CMD_READ_ARRAY);
  wire       is_conf  = (code == CMD_CONFIRM);
  wire       done_now = (state_reg == ST_BUSY) & arr_done;

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_PGM_POS] = perr_reg;
    status_byte[STAT_ERS_POS] = eerr_reg;
    status_byte[STAT_RDY_POS] = ready;
  end

  // ----------------------------------------
  // Result classification
  // ----------------------------------------
  fls_err_class u_class (
    .op               (op_reg),
    .lock_bit         (arr_lock_bit),
    .fail             (arr_fail),
    .lock_disable_bit (lock_disable_bit),
    .set_perr         (set_perr),
    .set_eerr         (set_eerr)
  );

  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    perr_next  = perr_reg;
    eerr_next  = eerr_reg;
    lock_next  = lock_reg;
    smode_next = smode_reg;
    start_next = 1'b0;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bus_wr) begin
          if (is_ra) begin
            smode_next = 1'b0;
          end else if (code == CMD_READ_STATUS) begin
            smode_next = 1'b1;
          end else if (code == CMD_CLR_STATUS) begin
            perr_next = 1'b0;
            eerr_next = 1'b0;
          end else if (first_op) begin
            cmd_next   = code;
            addr_next  = bus_addr;
            state_next = (code == CMD_PROGRAM) ? ST_PGM_W0 : ST_WAIT2;
          end else begin
            perr_next = 1'b1;
            eerr_next = 1'b1;
          end
        end
      end
      ST_WAIT2: begin
        if (bus_wr) begin
          state_next = ST_IDLE;
          if (is_ra) begin
            smode_next = 1'b0;
          end else if (!is_conf) begin
            perr_next = 1'b1;
            eerr_next = 1'b1;
          end else if (!err_any) begin
            // Refused silently while an error flag stands
            op_next    = op_of(cmd_reg);
            addr_next  = bus_addr;
            start_next = 1'b1;
            state_next = ST_BUSY;
            // Lock status read leaves status mode, the rest enter it
            smode_next = (cmd_reg != CMD_LOCK_RD);
          end
        end
      end
      ST_PGM_W0: begin
        if (bus_wr) begin
          wdata_next[15:0] = bus_wdata;
          addr_next        = bus_addr;
          state_next       = ST_PGM_W1;
        end
      end
      ST_PGM_W1: begin
        if (bus_wr) begin
          wdata_next[31:16] = bus_wdata;
          state_next        = ST_IDLE;
          if (!err_any) begin
            op_next    = OP_PROGRAM;
            start_next = 1'b1;
            state_next = ST_BUSY;
            smode_next = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        // Writes while busy are ignored
        if (done_now) begin
          state_next = ST_IDLE;
          // Results land on the same edge ready rises
          perr_next  = perr_reg | set_perr;
          eerr_next  = eerr_reg | set_eerr;
          if (op_reg == OP_LOCK_RD) begin
            lock_next = arr_lock_bit;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Status only in erase-write mode zero and at even addresses
  wire rd_status = erase_write_mode_zero & smode_reg
                 & ~bus_addr[0];
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_rd) begin
      rdata_next = rd_status ? {8'h00, status_byte} : arr_rdata;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg   <= 8'h00;
      perr_reg  <= PERR_RST;
      eerr_reg  <= EERR_RST;
      lock_reg  <= LOCK_FLAG_RST;
      smode_reg <= SMODE_RST;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      perr_reg  <= perr_next;
      eerr_reg  <= eerr_next;
      lock_reg  <= lock_next;
      smode_reg <= smode_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_reg  <= 1'b0;
      op_reg     <= OP_NONE;
      addr_reg   <= '0;
      wdata_reg  <= 32'h0000_0000;
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      start_reg  <= start_next;
      op_reg     <= op_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= bus_rd;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata            = rdata_reg;
  assign bus_rvalid           = rvalid_reg;
  assign sequencer_ready_flag = ready;
  assign program_error_flag   = perr_reg;
  assign erase_error_flag     = eerr_reg;
  assign lock_state_flag      = lock_reg;
  assign flash_status_byte    = status_byte;
  assign arr_start            = start_reg;
  assign arr_op               = op_reg;
  assign arr_addr             = addr_reg;
  assign arr_wdata            = wdata_reg;
  assign arr_lock_disable     = lock_disable_bit;
endmodule
`default_nettype wire

// *** sim/fls_seq_monitor.sv ***
// Port checker for the flash lock, blank and status sequencer
`default_nettype none
module fls_seq_monitor
  import fls_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_rvalid,
  input  wire logic        sequencer_ready_flag,
  input  wire logic        program_error_flag,
  input  wire logic        erase_error_flag,
  input  wire logic        lock_state_flag,
  input  wire logic [7:0]  flash_status_byte,
  input  wire logic        arr_start,
  input  wire fls_op_t     arr_op,
  input  wire logic        arr_done,
  input  wire logic        arr_fail,
  input  wire logic        arr_lock_bit
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic busy_done = !sequencer_ready_flag && arr_done;
  sequence s_lock_first;
    bus_wr && sequencer_ready_flag && bus_wdata[7:0] == CMD_LOCK_PGM;
  endsequence
  sequence s_bad_second;
    bus_wr && !program_error_flag && !erase_error_flag &&
    bus_wdata[7:0] != CMD_CONFIRM && bus_wdata[7:0] != CMD_READ_ARRAY;
  endsequence
  property p_stat_map;
    flash_status_byte == {sequencer_ready_flag, 1'h0, erase_error_flag,
                          program_error_flag, 4'h0};
  endproperty
  property p_start_busy;
    arr_start |-> !sequencer_ready_flag && $past(bus_wr);
  endproperty
  property p_done_ready;
    busy_done |=> sequencer_ready_flag;
  endproperty
  property p_hold_busy;
    !sequencer_ready_flag && !arr_done |=> !sequencer_ready_flag;
  endproperty
  property p_refuse;
    bus_wr && sequencer_ready_flag && bus_wdata[7:0] == CMD_CONFIRM &&
    (program_error_flag || erase_error_flag) |=> !arr_start;
  endproperty
  property p_clear_only;
    $fell(program_error_flag) || $fell(erase_error_flag) |->
      $past(bus_wr && bus_wdata[7:0] == CMD_CLR_STATUS);
  endproperty
  property p_blank;
    busy_done && arr_op == OP_BLANK |=> !program_error_flag &&
      erase_error_flag == $past(arr_fail || !arr_lock_bit);
  endproperty
  property p_lock_rd;
    busy_done && arr_op == OP_LOCK_RD |=>
      lock_state_flag == $past(arr_lock_bit);
  endproperty
  property p_rvalid;
    1'h1 |=> bus_rvalid == $past(bus_rd);
  endproperty
  property p_seq_err;
    s_lock_first ##1 s_bad_second |=> program_error_flag && erase_error_flag;
  endproperty
  a_stat_map: assert property (p_stat_map)
    else $error("status byte layout wrong");
  a_start_busy: assert property (p_start_busy)
    else $error("start without write or while ready");
  a_done_ready: assert property (p_done_ready)
    else $error("ready not back after done");
  a_hold_busy: assert property (p_hold_busy)
    else $error("ready rose without done");
  a_refuse: assert property (p_refuse)
    else $error("operation started despite error flag");
  a_clear_only: assert property (p_clear_only)
    else $error("error flag cleared without clear command");
  a_blank: assert property (p_blank)
    else $error("blank check result wrong");
  a_lock_rd: assert property (p_lock_rd)
    else $error("lock state flag wrong");
  a_rvalid: assert property (p_rvalid)
    else $error("read valid not one cycle after read");
  a_seq_err: assert property (p_seq_err)
    else $error("bad second cycle not flagged");
endmodule
bind fls_sequencer fls_seq_monitor i_mon (.clock, .rst, .bus_wr, .bus_rd,
  .bus_wdata, .bus_rvalid, .sequencer_ready_flag, .program_error_flag,
  .erase_error_flag, .lock_state_flag, .flash_status_byte, .arr_start,
  .arr_op, .arr_done, .arr_fail, .arr_lock_bit);
`default_nettype wire

// *** sim/fls_array_model.sv ***
// Behavioural flash array answering the sequencer
`default_nettype none
module fls_array_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       arr_start,
  input  wire logic [3:0] cfg_wait,
  input  wire logic       cfg_fail,
  input  wire logic       cfg_lock,
  output logic            arr_done,
  output logic            arr_fail,
  output logic            arr_lock_bit
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  logic       tog_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'h0;
      cnt_reg  <= 4'h0;
      tog_reg  <= 1'h0;
    end else begin
      tog_reg <= ~tog_reg;
      if (arr_start) begin
        busy_reg <= 1'h1;
        cnt_reg  <= cfg_wait;
      end else if (busy_reg && cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
      else if (arr_done) busy_reg <= 1'h0;
    end
  end
  assign arr_done = busy_reg && cnt_reg == 4'h0;
  // Off the done cycle results wander, so stale values are never trusted
  assign arr_fail     = arr_done ? cfg_fail : tog_reg;
  assign arr_lock_bit = arr_done ? cfg_lock : ~tog_reg;
endmodule
`default_nettype wire

// *** sim/flash_lock_blank_status_sequencer_bench.sv ***
// Self-checking bench for the flash sequencer
`default_nettype none
module flash_lock_blank_status_sequencer_bench
  import fls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] BA = 20'h07FFE;
  localparam logic [19:0] BB = 20'h0FFFE;
  logic clock, rst, bus_wr, bus_rd, bus_rvalid, erase_write_mode_zero;
  logic lock_disable_bit, sequencer_ready_flag, program_error_flag;
  logic erase_error_flag, lock_state_flag, arr_start, arr_lock_disable;
  logic arr_done, arr_fail, arr_lock_bit, m_fail, m_lock;
  logic [19:0] bus_addr, arr_addr;
  logic [15:0] bus_wdata, bus_rdata, arr_rdata;
  logic [31:0] arr_wdata;
  logic [7:0]  flash_status_byte;
  logic [3:0]  m_wait;
  fls_op_t     arr_op;
  int          fails, checks;
  fls_sequencer i_dut (.clock, .rst, .bus_wr, .bus_rd, .bus_addr, .bus_wdata,
    .bus_rdata, .bus_rvalid, .erase_write_mode_zero, .lock_disable_bit,
    .sequencer_ready_flag, .program_error_flag, .erase_error_flag,
    .lock_state_flag, .flash_status_byte, .arr_rdata, .arr_start, .arr_op,
    .arr_addr, .arr_wdata, .arr_lock_disable, .arr_done, .arr_fail,
    .arr_lock_bit);
  fls_array_model i_arr (.clock, .rst, .arr_start, .cfg_wait(m_wait),
    .cfg_fail(m_fail), .cfg_lock(m_lock), .arr_done, .arr_fail, .arr_lock_bit);
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'h1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Leaves the strobe high so writes can run back to back
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= {8'h5A, d};
    @(posedge clock);
  endtask
  task automatic clr;
    wr(BA, CMD_CLR_STATUS);
    bus_wr <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [15:0] e);
    bus_rd <= 1'h1;
    bus_addr <= 20'h00100;
    @(posedge clock);
    bus_rd <= 1'h0;
    #1;
    chk(bus_rvalid === 1'h1 && bus_rdata === e, "read data");
    @(posedge clock);
  endtask
  task automatic run(input logic [7:0] c, input logic [7:0] c2,
                     input logic [19:0] a, input logic f, input logic lk,
                     input logic go);
    int   i;
    logic seen;
    seen = 1'h0;
    m_fail <= f;
    m_lock <= lk;
    wr(a, c);
    wr(a, c2);
    bus_wr <= 1'h0;
    for (i = 0; i < 30; i++) begin
      #1;
      if (arr_start === 1'h1) begin
        seen = 1'h1;
        chk(arr_addr === a && sequencer_ready_flag === 1'h0, "start");
      end
      if (seen && sequencer_ready_flag === 1'h1) break;
      @(posedge clock);
    end
    chk(seen === go, "start expectation");
    if (seen && sequencer_ready_flag !== 1'h1) begin
      fails++;
      $display("BAD %0t ready timeout", $time);
      results();
    end
    @(posedge clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(flash_status_byte === 8'h80 && lock_state_flag === 1'h0, "rst");
    wr(BB, CMD_READ_STATUS);
    bus_wr <= 1'h0;
    @(posedge clock);
    rd(16'h0080);
  endtask
  task automatic t_lock;
    m_wait <= 4'h6;
    run(CMD_LOCK_PGM, CMD_CONFIRM, BA, 1'h0, 1'h1, 1'h1);
    chk(arr_op === OP_LOCK_PGM && program_error_flag === 1'h0, "lock");
    run(CMD_LOCK_RD, CMD_CONFIRM, BA, 1'h0, 1'h0, 1'h1);
    chk(lock_state_flag === 1'h0, "lock state 0");
    m_wait <= 4'h0;
    run(CMD_LOCK_RD, CMD_CONFIRM, BA, 1'h0, 1'h1, 1'h1);
    chk(lock_state_flag === 1'h1, "lock state 1");
    run(CMD_LOCK_PGM, CMD_CONFIRM, BA, 1'h1, 1'h1, 1'h1);
    chk(program_error_flag === 1'h1 && erase_error_flag === 1'h0, "perr");
    clr();
    chk(program_error_flag === 1'h0, "clear");
    lock_disable_bit <= 1'h1;
    run(CMD_LOCK_PGM, CMD_CONFIRM, BA, 1'h1, 1'h1, 1'h1);
    chk(program_error_flag === 1'h0, "suppressed");
    lock_disable_bit <= 1'h0;
  endtask
  task automatic t_blank;
    m_wait <= 4'h3;
    run(CMD_BLANK, CMD_CONFIRM, BB, 1'h0, 1'h1, 1'h1);
    chk(erase_error_flag === 1'h0, "blank ok");
    run(CMD_BLANK, CMD_CONFIRM, BB, 1'h1, 1'h1, 1'h1);
    chk(erase_error_flag === 1'h1 && program_error_flag === 1'h0, "nb");
    rd(16'h00A0);
    run(CMD_LOCK_RD, CMD_CONFIRM, BA, 1'h0, 1'h0, 1'h0);
    chk(lock_state_flag === 1'h1 && erase_error_flag === 1'h1, "refused");
    clr();
    lock_disable_bit <= 1'h1;
    run(CMD_BLANK, CMD_CONFIRM, BB, 1'h0, 1'h0, 1'h1);
    chk(erase_error_flag === 1'h1, "locked blank");
    lock_disable_bit <= 1'h0;
    clr();
  endtask
  task automatic t_seqerr;
    logic [7:0] codes [5];
    codes = '{CMD_ERASE, CMD_LOCK_PGM, CMD_LOCK_RD, CMD_BLANK, 8'h33};
    foreach (codes[k]) begin
      wr(BA, codes[k]);
      wr(BA, 8'h3C);
      bus_wr <= 1'h0;
      @(posedge clock);
      chk(program_error_flag === 1'h1 && erase_error_flag === 1'h1, "seq");
      clr();
    end
  endtask
  task automatic t_prog;
    m_wait <= 4'h2;
    wr(BB, CMD_PROGRAM);
    run(8'h12, 8'h34, BB, 1'h0, 1'h0, 1'h1);
    chk(arr_op === OP_PROGRAM, "pgm op");
    chk(arr_wdata === 32'h5A34_5A12, "pgm data");
    chk(program_error_flag === 1'h1 && erase_error_flag === 1'h0, "pl");
    rd(16'h0090);
    erase_write_mode_zero <= 1'h0;
    rd(16'hC3A5);
    erase_write_mode_zero <= 1'h1;
    clr();
    lock_disable_bit <= 1'h1;
    wr(BB, CMD_PROGRAM);
    run(8'h12, 8'h34, BB, 1'h0, 1'h0, 1'h1);
    chk(program_error_flag === 1'h0, "pgm suppressed");
    chk(arr_lock_disable === 1'h1, "lock disable out");
    lock_disable_bit <= 1'h0;
    run(CMD_ERASE, CMD_CONFIRM, BA, 1'h0, 1'h0, 1'h1);
    chk(erase_error_flag === 1'h1 && program_error_flag === 1'h0, "el");
    clr();
  endtask
  task automatic t_cancel;
    run(CMD_LOCK_PGM, CMD_READ_ARRAY, BA, 1'h0, 1'h1, 1'h0);
    chk(program_error_flag === 1'h0 && erase_error_flag === 1'h0, "cancel");
    rd(16'hC3A5);
  endtask
  initial begin
    fails = 0;
    checks = 0;
    rst = 1'h1;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_addr = 20'h00000;
    bus_wdata = 16'h0000;
    erase_write_mode_zero = 1'h1;
    lock_disable_bit = 1'h0;
    arr_rdata = 16'hC3A5;
    m_wait = 4'h0;
    m_fail = 1'h0;
    m_lock = 1'h1;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_reset();
    t_lock();
    t_blank();
    t_seqerr();
    t_prog();
    t_cancel();
    results();
  end
endmodule
`default_nettype wire
